// *** hdl/stm_params.svh ***
/*
  Constants of the compare-output timer: register byte offsets, field positions and reset values.
  Assumes the including file sits on the classic Wishbone bus with 32-bit data and byte addresses.
*/
// Contract
// [RL1] Compare mode: control bit gives initial pin level.
// [RL2] Waveform modes: control bit gives active level.
// [RL3] Invert bit flips pin, not in timer mode.
// [RL4] Swap bit exchanges period and duty registers.
// [RL5] Clear-select picks compare-A or compare-P/overflow clear.
// [RL6] Compare-P zero means overflow at maximum count.
// [RL7] Clear-select ignored in PWM, pulse, capture.
// [RL8] Counter readable as two zero-reset read-only bytes.
// [RL9] Compare-A held in two zero-reset byte registers.
// [RL10] Compare-P checks only counter bits fifteen to eight.
// [RL11] Compare-P period is value times 256, zero 65536.
// [RL12] Two-bit mode field selects four operating modes.
// [RL13] Mode 00 is compare output with three clears.
// [RL14] Clear-select zero raises both match flags.
// [RL15] Clear-select one raises only the compare-A flag.
// [RL16] Software never writes compare-A zero in compare mode.
// [RL17] Only compare-A matches change the output pin.
// [RL18] Pin function: high, low, toggle, or unchanged.
// [RL19] Run bit rising loads the initial pin level.
// [RL20] Modes 01 capture, 10 waveform, 11 timer.
// [RL21] Timer mode counts like compare mode, pin unused.
// [RL22] Pin function codes: 01 low, 10 high, 11 toggle.
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH

`define STM_OFS_CTRL_ONE   8'h00
`define STM_OFS_COUNT_LOW  8'h04
`define STM_OFS_COUNT_HIGH 8'h08
`define STM_OFS_CMP_A_LOW  8'h0C
`define STM_OFS_CMP_A_HIGH 8'h10
`define STM_OFS_CMP_P      8'h14
`define STM_OFS_RUN        8'h18
`define STM_OFS_FLAGS      8'h1C

`define STM_POS_MODE_HI    7
`define STM_POS_MODE_LO    6
`define STM_POS_PINF_HI    5
`define STM_POS_PINF_LO    4
`define STM_POS_INIT_LEVEL 3
`define STM_POS_INVERT     2
`define STM_POS_SWAP       1
`define STM_POS_CLEAR_SEL  0
`define STM_POS_RUN        0
`define STM_POS_FLAG_A     0
`define STM_POS_FLAG_P     1

`define STM_RST_BYTE       8'h00
`define STM_RST_COUNT      16'h0000
`define STM_LOW_BYTE_TOP   8'hFF

`endif

// *** hdl/stm_pkg.sv ***
/*
  Types shared by the compare-output timer: operating mode and pin function encodings.
  Assumes nothing of its surroundings.
*/
package stm_pkg;

  typedef enum logic [1:0] {
    STM_MODE_COMPARE = 2'h0,
    STM_MODE_CAPTURE = 2'h1,
    STM_MODE_WAVE    = 2'h2,
    STM_MODE_TIMER   = 2'h3
  } stm_mode_t;

  typedef enum logic [1:0] {
    STM_PINF_HOLD   = 2'h0,
    STM_PINF_LOW    = 2'h1,
    STM_PINF_HIGH   = 2'h2,
    STM_PINF_TOGGLE = 2'h3
  } stm_pinf_t;

endpackage

// *** hdl/stm_timer.sv ***
/*
  Sixteen-bit standard timer with compare-A / coarse compare-P matching, compare output,
  simple PWM and single pulse output, reached over a classic Wishbone slave port.
  Assumes one 10 MHz clock that is also the timer clock, and a synchronous active-high reset.
*/
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "stm_params.svh"

module stm_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             timer_output_pin_o,
  output logic             timer_output_pin_oe_o
);

  logic [7:0]            timer_control_one;
  logic [7:0]            compare_a_low;
  logic [7:0]            compare_a_high;
  logic [7:0]            compare_p_coarse;
  logic                  timer_run_bit;
  logic                  run_q;
  logic [15:0]           count;
  logic [1:0]            flags;
  logic                  pin_level;
  logic                  next_pin;
  logic [31:0]           next_rd;
  logic                  wr_en;
  logic [15:0]           compare_a_value;
  logic [15:0]           p_match_count;
  stm_pkg::stm_mode_t    mode;
  stm_pkg::stm_pinf_t    pin_function;
  logic                  init_level;
  logic                  output_invert;
  logic                  period_duty_swap;
  logic                  clear_select;
  logic                  is_cmp;
  logic                  is_tc;
  logic                  cmp_like;
  logic                  is_cap;
  logic                  is_pwm;
  logic                  is_sp;
  logic                  run_rise;
  logic                  active;
  logic                  a_match;
  logic                  p_match;
  logic                  clear_now;
  logic                  sp_end;
  logic                  duty_on;
  logic                  wave_on;
  logic [1:0]            flag_set;
  logic [1:0]            flag_clr;

  assign mode             = stm_pkg::stm_mode_t'(timer_control_one[`STM_POS_MODE_HI:`STM_POS_MODE_LO]); // [RL12]
  assign pin_function     = stm_pkg::stm_pinf_t'(timer_control_one[`STM_POS_PINF_HI:`STM_POS_PINF_LO]);
  assign init_level       = timer_control_one[`STM_POS_INIT_LEVEL];
  assign output_invert    = timer_control_one[`STM_POS_INVERT];
  assign period_duty_swap = timer_control_one[`STM_POS_SWAP];
  assign clear_select     = timer_control_one[`STM_POS_CLEAR_SEL];

  // Mode decode: 00 compare, 01 capture, 10 PWM or single pulse, 11 timer.
  assign is_cmp   = (mode == stm_pkg::STM_MODE_COMPARE); // [RL13] [RL20]
  assign is_tc    = (mode == stm_pkg::STM_MODE_TIMER); // [RL20]
  assign is_cap   = (mode == stm_pkg::STM_MODE_CAPTURE); // [RL20]
  assign cmp_like = is_cmp | is_tc; // [RL21]
  assign is_sp    = (mode == stm_pkg::STM_MODE_WAVE) & (pin_function == stm_pkg::STM_PINF_TOGGLE);
  assign is_pwm   = (mode == stm_pkg::STM_MODE_WAVE) & ~is_sp;

  assign compare_a_value = {compare_a_high, compare_a_low};
  assign run_rise        = timer_run_bit & ~run_q;
  assign active          = timer_run_bit & run_q;

  // Compare-P sees only the high byte; the match sits on the last count of the 256-step block it selects,
  // so a value of zero wraps to all ones and the clear then coincides with overflow.
  assign p_match_count = {8'(compare_p_coarse - 8'h01), `STM_LOW_BYTE_TOP}; // [RL10] [RL11] [RL6]
  assign a_match       = active & (count == compare_a_value);
  assign p_match       = active & (count == p_match_count); // [RL10]

  always_comb
  begin
    if (cmp_like)
      clear_now = clear_select ? a_match : p_match; // [RL5] [RL13]
    else if (is_pwm)
      clear_now = period_duty_swap ? a_match : p_match; // [RL4] [RL7]
    else if (is_cap)
      clear_now = p_match; // [RL7]
    else
      clear_now = 1'b0;
  end

  // Single pulse ends on a compare-A match; the run bit then drops and the counter stops.
  assign sp_end = is_sp & a_match;

  // Capture events are not modelled, so capture mode raises no compare-A flag.
  assign flag_set[`STM_POS_FLAG_A] = a_match & ~is_cap; // [RL14] [RL15]
  assign flag_set[`STM_POS_FLAG_P] = p_match & ~(cmp_like & clear_select) & ~is_sp; // [RL14] [RL15]

  assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign flag_clr = (wr_en && wb_adr_i == `STM_OFS_FLAGS) ? wb_dat_i[1:0] : 2'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_control_one <= `STM_RST_BYTE;
    else if (wr_en && wb_adr_i == `STM_OFS_CTRL_ONE)
      timer_control_one <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      compare_a_low  <= `STM_RST_BYTE;
      compare_a_high <= `STM_RST_BYTE;
    end
    else if (wr_en && wb_adr_i == `STM_OFS_CMP_A_LOW)
      compare_a_low <= wb_dat_i[7:0]; // [RL9]
    else if (wr_en && wb_adr_i == `STM_OFS_CMP_A_HIGH)
      compare_a_high <= wb_dat_i[7:0]; // [RL9]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      compare_p_coarse <= `STM_RST_BYTE;
    else if (wr_en && wb_adr_i == `STM_OFS_CMP_P)
      compare_p_coarse <= wb_dat_i[7:0];
  end

  // A software write to the run register takes precedence over the pulse-end clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_run_bit <= 1'b0;
    else if (wr_en && wb_adr_i == `STM_OFS_RUN)
      timer_run_bit <= wb_dat_i[`STM_POS_RUN];
    else if (sp_end)
      timer_run_bit <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      run_q <= 1'b0;
    else
      run_q <= timer_run_bit;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= `STM_RST_COUNT; // [RL8]
    else if (run_rise || clear_now)
      count <= `STM_RST_COUNT; // [RL5]
    else if (timer_run_bit)
      count <= 16'(count + 16'h0001); // [RL6]
  end

  // Hardware sets win over a software clear landing in the same cycle.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_flag
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          flags[g] <= 1'b0;
        else if (flag_set[g])
          flags[g] <= 1'b1; // [RL14]
        else if (flag_clr[g])
          flags[g] <= 1'b0;
      end
    end
  endgenerate

  // Duty by compare-A, or by compare-P times 256 when swapped; zero there means the full 65536.
  always_comb
  begin
    if (period_duty_swap)
      duty_on = (compare_p_coarse == 8'h00) | (count < {compare_p_coarse, 8'h00}); // [RL4]
    else
      duty_on = (count < compare_a_value); // [RL4]
    case (pin_function)
      stm_pkg::STM_PINF_HOLD:   wave_on = 1'b0;
      stm_pkg::STM_PINF_LOW:    wave_on = 1'b1;
      stm_pkg::STM_PINF_HIGH:   wave_on = timer_run_bit & duty_on;
      stm_pkg::STM_PINF_TOGGLE: wave_on = timer_run_bit & ~sp_end;
      default:                  wave_on = 1'b0;
    endcase
  end

  always_comb
  begin
    next_pin = pin_level;
    if (is_cmp)
    begin
      if (run_rise)
        next_pin = init_level; // [RL19] [RL1]
      else if (a_match)
      begin
        case (pin_function) // [RL17] [RL18] [RL22]
          stm_pkg::STM_PINF_LOW:    next_pin = 1'b0;
          stm_pkg::STM_PINF_HIGH:   next_pin = 1'b1;
          stm_pkg::STM_PINF_TOGGLE: next_pin = ~pin_level;
          default:                  next_pin = pin_level;
        endcase
      end
    end
    else if (is_pwm || is_sp)
      next_pin = wave_on ? init_level : ~init_level; // [RL2]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_level <= 1'b0;
    else
      pin_level <= next_pin;
  end

  // The pin is released in timer and capture modes so it can serve another function.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_output_pin_o    <= 1'b0;
      timer_output_pin_oe_o <= 1'b0;
    end
    else
    begin
      timer_output_pin_o    <= is_tc ? 1'b0 : (next_pin ^ output_invert); // [RL3] [RL21]
      timer_output_pin_oe_o <= ~is_tc & ~is_cap; // [RL21]
    end
  end

  always_comb
  begin
    next_rd = 32'h00000000;
    case (wb_adr_i)
      `STM_OFS_CTRL_ONE:   next_rd[7:0] = timer_control_one;
      `STM_OFS_COUNT_LOW:  next_rd[7:0] = count[7:0]; // [RL8]
      `STM_OFS_COUNT_HIGH: next_rd[7:0] = count[15:8]; // [RL8]
      `STM_OFS_CMP_A_LOW:  next_rd[7:0] = compare_a_low;
      `STM_OFS_CMP_A_HIGH: next_rd[7:0] = compare_a_high;
      `STM_OFS_CMP_P:      next_rd[7:0] = compare_p_coarse;
      `STM_OFS_RUN:        next_rd[`STM_POS_RUN] = timer_run_bit;
      `STM_OFS_FLAGS:      next_rd[1:0] = flags;
      default:             next_rd = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      wb_dat_o <= next_rd;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_init_level_load: // [RL19]
    assert property (is_cmp && run_rise |=> pin_level == $past(init_level))
      else $error("Pin did not take the initial level on run start.");

  a_pin_quiet_no_a: // [RL17]
    assert property (is_cmp && !a_match && !run_rise |=> pin_level == $past(pin_level))
      else $error("Pin moved without a compare-A match.");

  a_fn_drive_low: // [RL22]
    assert property (is_cmp && !run_rise && a_match && pin_function == stm_pkg::STM_PINF_LOW |=> !pin_level)
      else $error("Function 01 did not drive the pin low.");

  a_fn_toggle_pin: // [RL18]
    assert property (is_cmp && !run_rise && a_match && pin_function == stm_pkg::STM_PINF_TOGGLE
                     |=> pin_level != $past(pin_level))
      else $error("Function 11 did not toggle the pin.");

  a_clear_on_a: // [RL5]
    assert property (cmp_like && clear_select && a_match |=> count == 16'h0000)
      else $error("Compare-A match did not clear the counter.");

  a_clear_on_p: // [RL5]
    assert property (cmp_like && !clear_select && p_match |=> count == 16'h0000)
      else $error("Compare-P match did not clear the counter.");

  a_no_p_flag: // [RL15]
    assert property (cmp_like && clear_select && !flags[`STM_POS_FLAG_P] |=> !flags[`STM_POS_FLAG_P])
      else $error("Compare-P flag rose with clear-select high.");

  a_a_flag_raise: // [RL14]
    assert property (cmp_like && a_match |=> flags[`STM_POS_FLAG_A])
      else $error("Compare-A flag not raised on match.");

  a_timer_pin_off: // [RL21]
    assert property ($past(is_tc) |-> !timer_output_pin_oe_o && !timer_output_pin_o)
      else $error("Pin driven in timer mode.");

  a_count_step_up: // [RL8]
    assert property (timer_run_bit && !run_rise && !clear_now |=> count == 16'($past(count) + 16'h0001))
      else $error("Counter did not advance by one.");

  a_invert_applied: // [RL3]
    assert property (!is_tc ##1 1'b1 |-> timer_output_pin_o == ($past(next_pin) ^ $past(output_invert)))
      else $error("Pin polarity does not follow the invert bit.");

  a_fn_drive_high: // [RL22]
    assert property (is_cmp && !run_rise && a_match && pin_function == stm_pkg::STM_PINF_HIGH |=> pin_level)
      else $error("Function 10 did not drive the pin high.");

  a_fn_hold_pin: // [RL18]
    assert property (is_cmp && !run_rise && a_match && pin_function == stm_pkg::STM_PINF_HOLD
                     |=> pin_level == $past(pin_level))
      else $error("Function 00 moved the pin.");

  a_p_flag_raise: // [RL14]
    assert property (cmp_like && !clear_select && p_match |=> flags[`STM_POS_FLAG_P])
      else $error("Compare-P flag not raised on match.");

  a_wave_p_clear: // [RL7] [RL4]
    assert property (is_pwm && !period_duty_swap && p_match |=> count == 16'h0000)
      else $error("Waveform period did not end on compare-P match.");

  a_capture_pin_off: // [RL20]
    assert property ($past(is_cap) |-> !timer_output_pin_oe_o)
      else $error("Pin driven in capture mode.");

endmodule

// *** verif/stm_timer_tb_top.sv ***
/*
  Self-checking bench for the compare-output timer: register access, compare output and timer modes.
  Assumes the design's include path holds stm_params.svh and that stm_pkg is compiled first.
*/
`timescale 1ns/1ns
`include "stm_params.svh"

module stm_timer_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pin;
  logic        oe;
  logic [31:0] q;
  int          n_mismatch;
  int          num_checks;
  int          seed;
  int          n;
  logic [15:0] a;

  stm_timer i_dut (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .wb_cyc_i              (wb_cyc_i),
    .wb_stb_i              (wb_stb_i),
    .wb_we_i               (wb_we_i),
    .wb_adr_i              (wb_adr_i),
    .wb_sel_i              (wb_sel_i),
    .wb_dat_i              (wb_dat_i),
    .wb_dat_o              (wb_dat_o),
    .wb_ack_o              (wb_ack_o),
    .timer_output_pin_o    (pin),
    .timer_output_pin_oe_o (oe)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // One classic cycle; the request stays put until ack is seen at a rising edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1)
    begin
      n_mismatch++;
      close_out();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Falling edges from the current one until the pin changes; callers already sit on a falling edge,
  // so two calls in a row measure one full segment between pin changes.
  task automatic wait_edge(output int cnt);
    logic p0;
    cnt = 0;
    p0 = pin;
    do
    begin
      @(negedge clk_i);
      cnt++;
    end
    while (pin === p0 && cnt < 70000);
    if (cnt >= 70000)
    begin
      n_mismatch++;
      close_out();
    end
  endtask

  function automatic int exp_period(input logic csel, input logic [15:0] av, input logic [7:0] pv);
    if (csel)
      return av + 1;
    return (pv == 8'h00) ? 65536 : pv * 256;
  endfunction

  function automatic logic exp_pin(input logic [1:0] fn, input logic init);
    if (fn == stm_pkg::STM_PINF_LOW)
      return 1'b0;
    if (fn == stm_pkg::STM_PINF_HIGH)
      return 1'b1;
    return init;
  endfunction

  // Stops the timer, clears flags, programs it and starts it again.
  task automatic start(input logic [1:0] md, input logic [1:0] fn, input logic init, input logic inv,
                       input logic csel, input logic [15:0] av, input logic [7:0] pv, input logic sw);
    wb(1'b1, `STM_OFS_RUN, 8'h00);
    wb(1'b1, `STM_OFS_FLAGS, 8'h03);
    wb(1'b1, `STM_OFS_CTRL_ONE, {md, fn, init, inv, sw, csel});
    wb(1'b1, `STM_OFS_CMP_A_LOW, av[7:0]);
    wb(1'b1, `STM_OFS_CMP_A_HIGH, av[15:8]);
    wb(1'b1, `STM_OFS_CMP_P, pv);
    wb(1'b1, `STM_OFS_RUN, 8'h01);
    repeat (3) @(negedge clk_i);
  endtask

  initial
  begin
    seed = 51932;
    n_mismatch = 0;
    num_checks = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      wb(1'b0, 8'(i * 4), 8'h00);
      chk(q, 32'h00000000);
    end
    wb(1'b1, `STM_OFS_COUNT_LOW, 8'hFF);
    wb(1'b0, `STM_OFS_COUNT_LOW, 8'h00);
    chk(q, 32'h00000000);
    for (int i = 0; i < 4; i++)
    begin
      a = 16'($random(seed));
      wb(1'b1, 8'h0C + 8'(i * 4), a[7:0]);
      wb(1'b0, 8'h0C + 8'(i * 4), 8'h00);
      chk(q, (i == 3) ? {31'h0, a[0]} : {24'h000000, a[7:0]});
    end
    // The hold, low and high pin functions, each from the level it cannot already hold.
    for (int f = 0; f < 3; f++)
    begin
      a = 16'd8 + 16'($unsigned($random(seed)) % 33);
      start(stm_pkg::STM_MODE_COMPARE, 2'(f), f != 2, f == 1, 1'b1, a, 8'h01, 1'b0);
      chk({31'h0, pin}, {31'h0, (f != 2) ^ (f == 1)});
      chk({31'h0, oe}, 32'h00000001);
      repeat (a + 4) @(negedge clk_i);
      chk({31'h0, pin}, {31'h0, exp_pin(2'(f), f != 2) ^ (f == 1)});
    end
    a = 16'd8 + 16'($unsigned($random(seed)) % 57);
    start(stm_pkg::STM_MODE_COMPARE, stm_pkg::STM_PINF_TOGGLE, 1'b0, 1'b0, 1'b1, a, 8'h01, 1'b0);
    wait_edge(n);
    wait_edge(n);
    chk(n, exp_period(1'b1, a, 8'h01));
    // Compare-P below compare-A must still raise no P flag.
    start(stm_pkg::STM_MODE_COMPARE, stm_pkg::STM_PINF_TOGGLE, 1'b1, 1'b0, 1'b1, 16'h0180, 8'h01, 1'b0);
    wait_edge(n);
    wait_edge(n);
    chk(n, exp_period(1'b1, 16'h0180, 8'h01));
    wb(1'b0, `STM_OFS_FLAGS, 8'h00);
    chk(q, 32'h00000001);
    for (int p = 1; p < 3; p++)
    begin
      start(stm_pkg::STM_MODE_COMPARE, stm_pkg::STM_PINF_TOGGLE, 1'b0, 1'b0, 1'b0, 16'h0005, 8'(p), 1'b0);
      wait_edge(n);
      wait_edge(n);
      chk(n, exp_period(1'b0, 16'h0005, 8'(p)));
      wb(1'b0, `STM_OFS_FLAGS, 8'h00);
      chk(q, 32'h00000003);
    end
    wb(1'b1, `STM_OFS_FLAGS, 8'h03);
    wb(1'b0, `STM_OFS_FLAGS, 8'h00);
    chk(q[0], 1'b0);
    // Waveform mode, active low with the invert bit set, so the pin reads high while active.
    start(stm_pkg::STM_MODE_WAVE, stm_pkg::STM_PINF_HIGH, 1'b0, 1'b1, 1'b1, 16'h0040, 8'h01, 1'b0);
    chk({31'h0, pin}, 32'h00000001);
    wait_edge(n);
    chk(n, 64);
    wait_edge(n);
    chk(n, 256 - 64);
    wb(1'b1, `STM_OFS_CTRL_ONE, 8'h95);
    repeat (2) @(negedge clk_i);
    chk({31'h0, pin}, 32'h00000001);
    wb(1'b1, `STM_OFS_CTRL_ONE, 8'h85);
    repeat (2) @(negedge clk_i);
    chk({31'h0, pin}, 32'h00000000);
    // Swapped roles: compare-A sets the period, compare-P times 256 the active time.
    start(stm_pkg::STM_MODE_WAVE, stm_pkg::STM_PINF_HIGH, 1'b1, 1'b0, 1'b0, 16'h017F, 8'h01, 1'b1);
    wait_edge(n);
    chk(n, 256);
    wait_edge(n);
    chk(n, 384 - 256);
    // Single pulse: active until the compare-A match ends the run and stops the counter.
    start(stm_pkg::STM_MODE_WAVE, stm_pkg::STM_PINF_TOGGLE, 1'b1, 1'b0, 1'b0, 16'h0140, 8'h01, 1'b0);
    chk({31'h0, pin}, 32'h00000001);
    wait_edge(n);
    chk(n, 320);
    wb(1'b0, `STM_OFS_RUN, 8'h00);
    chk(q, 32'h00000000);
    wb(1'b0, `STM_OFS_FLAGS, 8'h00);
    chk(q, 32'h00000001);
    wb(1'b0, `STM_OFS_COUNT_HIGH, 8'h00);
    chk(q, 32'h00000001);
    wb(1'b0, `STM_OFS_COUNT_LOW, 8'h00);
    chk(q, 32'h00000041);
    // Timer mode, then capture mode with clear-select set, which it must ignore.
    for (int m = 0; m < 2; m++)
    begin
      start(m ? stm_pkg::STM_MODE_CAPTURE : stm_pkg::STM_MODE_TIMER, stm_pkg::STM_PINF_TOGGLE, 1'b1, 1'b1,
            m == 1, 16'h0005, 8'h01, 1'b0);
      n = 0;
      repeat (300)
      begin
        @(negedge clk_i);
        if (oe !== 1'b0 || (m == 0 && pin !== 1'b0))
          n++;
      end
      chk(n, 0);
      wb(1'b0, `STM_OFS_FLAGS, 8'h00);
      chk(q, m ? 32'h00000002 : 32'h00000003);
    end
    wb(1'b0, 8'h20, 8'h00);
    chk(q, 32'h00000000);
    close_out();
  end
endmodule
